/* File: dv/modem_ctl_tb.sv */
// Purpose: Self-checking bench for the modem pin block
// Assumes: Reads use the high strobe only
// Notes:   Ring and receiver clock come from the modem model
`timescale 1ns/1ps
`include "modem_ctl_params.svh"
`default_nettype none

module modem_ctl_tb;
	logic mclk_in = 0, rstn_in = 0, sel = 1, rh = 0, ws = 0;
	logic ring = 0, cen = 0, thr = 0;
	logic [`ADDR_W-1:0] ad = 0;
	logic [`DATA_W-1:0] wd = 0, rv, rdata;
	logic ring_n, rclk, thr_p, rts_n, oa_n, ob_n, stk, btk, irq;
	int err_total = 0, checked = 0, nbit = 0, nstk = 0;
	always #4 mclk_in = ~mclk_in;
	always @(posedge mclk_in) if (btk === 1'b1) nbit++;
	always @(posedge mclk_in) if (stk === 1'b1) nstk++;
	modem_model mdm_u (.ring_in(ring), .clk_en_in(cen), .thr_in(thr),
		.ring_n_out(ring_n), .rclk_out(rclk), .thr_out(thr_p));
	modem_ctl dut_u (.mclk_in(mclk_in), .rstn_in(rstn_in),
		.chip_select_a_in(sel), .chip_select_b_in(1'b1),
		.chip_select_c_low_n_in(1'b0),
		.read_strobe_low_active_n_in(1'b1),
		.read_strobe_high_active_in(rh), .write_strobe_in(ws),
		.addr_in(ad), .wdata_in(wd), .rdata_out(rdata),
		.ring_indicator_n_in(ring_n), .rx_clock_in(rclk),
		.rx_threshold_in(thr_p), .rts_n_out(rts_n),
		.user_output_a_n_out(oa_n), .user_output_b_n_out(ob_n),
		.rx_sample_tick_out(stk), .rx_bit_tick_out(btk),
		.irq_out(irq));
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h",
				$time, s, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		ws <= 1'b1;
		ad <= a;
		wd <= d;
		@(posedge mclk_in);
		ws <= 1'b0;
		#1;
	endtask
	// Unselected read when s is 0
	task automatic rd(input logic [2:0] a, input logic s);
		@(posedge mclk_in);
		ad <= a;
		rh <= 1'b1;
		sel <= s;
		@(posedge mclk_in);
		rh <= 1'b0;
		sel <= 1'b1;
		#1;
		rv = rdata;
	endtask
	function automatic logic [7:0] pins();
		return 8'({rts_n, oa_n, ob_n});
	endfunction
	task automatic t_pins();
		chk(pins(), 8'h07);
		wr(`OFF_MCTRL, 8'h0E);
		chk(pins(), 8'h00);
		wr(`OFF_MCTRL, 8'h1E);
		chk(pins(), 8'h07);
		wr(`OFF_MCTRL, 8'h04);
		chk(pins(), 8'h05);
		wr(`OFF_MCTRL, 8'h08);
		chk(pins(), 8'h06);
	endtask
	task automatic t_ring();
		@(posedge mclk_in) ring <= 1'b1;
		cyc(6);
		rd(`OFF_MSTAT, 1'b1);
		chk(8'(rv[6]), 8'h01);
		chk(8'(rv[2]), 8'h00);
		@(posedge mclk_in) ring <= 1'b0;
		cyc(6);
		chk(8'(irq), 8'h00);
		rd(`OFF_MSTAT, 1'b0);
		chk(rv, 8'h00);
		rd(`OFF_MSTAT, 1'b1);
		chk(8'({rv[6], rv[2]}), 8'h01);
		rd(`OFF_MSTAT, 1'b1);
		chk(8'(rv[2]), 8'h00);
		wr(`OFF_IRQ_CLR, 8'h01);
		wr(`OFF_IRQ_EN, 8'h01);
		chk(8'(irq), 8'h00);
		@(posedge mclk_in) ring <= 1'b1;
		cyc(6);
		@(posedge mclk_in) ring <= 1'b0;
		cyc(6);
		chk(8'(irq), 8'h01);
		wr(`OFF_IRQ_CLR, 8'h01);
		chk(8'(irq), 8'h00);
	endtask
	task automatic t_auto();
		wr(`OFF_IRQ_EN, 8'h02);
		wr(`OFF_MCTRL, 8'h22);
		chk(8'(rts_n), 8'h00);
		@(posedge mclk_in) thr <= 1'b1;
		cyc(4);
		chk(8'({rts_n, irq}), 8'h03);
		rd(`OFF_IRQ_STAT, 1'b1);
		chk(rv, 8'h02);
		rd(`OFF_MCTRL, 1'b1);
		chk(rv, 8'h22);
		rd(`OFF_IRQ_EN, 1'b1);
		chk(rv, 8'h02);
		rd(3'h5, 1'b1);
		chk(rv, 8'h00);
		@(posedge mclk_in) thr <= 1'b0;
		cyc(4);
		wr(`OFF_IRQ_CLR, 8'h02);
		chk(8'({rts_n, irq}), 8'h00);
	endtask
	task automatic t_rx();
		@(posedge mclk_in) cen <= 1'b1;
		repeat (32) @(posedge rclk);
		cen <= 1'b0;
		cyc(6);
		rd(`OFF_TICKS, 1'b1);
		chk(rv, 8'h20);
		chk(8'(nbit), 8'h02);
		chk(8'(nstk), 8'h20);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#50000;
		err_total++;
		print_verdict();
	end
	initial begin
		repeat (8) @(posedge mclk_in);
		rstn_in <= 1'b1;
		cyc(1);
		t_pins();
		t_ring();
		t_auto();
		t_rx();
		print_verdict();
	end
endmodule // modem_ctl_tb

`default_nettype wire

/* File: dv/modem_model.sv */
// Purpose: Modem side of the ring and receiver clock lines
// Assumes: Bench commands ring level, clock run and threshold
// Notes:   Receiver clock stands still unless enabled
`timescale 1ns/1ps
`default_nettype none

module modem_model (
	// Commands from the bench
	input  wire logic ring_in,
	input  wire logic clk_en_in,
	input  wire logic thr_in,
	// Lines toward the block
	output logic      ring_n_out,
	output logic      rclk_out,
	output logic      thr_out
);
	// Ring line is active low
	assign ring_n_out = ~ring_in;
	assign thr_out = thr_in;
	// Free of the system clock in phase
	initial begin
		rclk_out = 1'b0;
		forever #20 if (clk_en_in) rclk_out = ~rclk_out;
	end
endmodule // modem_model

`default_nettype wire

/* File: hw/modem_ctl.sv */
// Purpose: Modem control outputs, ring status and receiver clock
// Assumes: Bus strobes come from logic on mclk_in
// Notes:   Ring and receiver clock pins are synchronised first
`timescale 1ns/1ps
`include "modem_ctl_params.svh"
`default_nettype none

module modem_ctl (
	// Clock and reset
	input  wire logic                 mclk_in,
	input  wire logic                 rstn_in,
	// Register port with chip selects
	input  wire logic                 chip_select_a_in,
	input  wire logic                 chip_select_b_in,
	input  wire logic                 chip_select_c_low_n_in,
	input  wire logic                 read_strobe_low_active_n_in,
	input  wire logic                 read_strobe_high_active_in,
	input  wire logic                 write_strobe_in,
	input  wire logic [`ADDR_W-1:0]   addr_in,
	input  wire logic [`DATA_W-1:0]   wdata_in,
	output logic      [`DATA_W-1:0]   rdata_out,
	// Modem side pins
	input  wire logic                 ring_indicator_n_in,
	input  wire logic                 rx_clock_in,
	input  wire logic                 rx_threshold_in,
	output logic                      rts_n_out,
	output logic                      user_output_a_n_out,
	output logic                      user_output_b_n_out,
	// Receiver timing and interrupt
	output logic                      rx_sample_tick_out,
	output logic                      rx_bit_tick_out,
	output logic                      irq_out
);

	modem_ctl_pkg::state_t   q;
	modem_ctl_pkg::state_t   d;
	modem_ctl_pkg::bus_req_t req;
	logic                    ri_rise;
	logic                    rclk_rise;
	logic                    mstat_rd;

	function automatic logic selected(input logic a, input logic b,
			input logic c_n);
		selected = a & b & ~c_n;
	endfunction

	function automatic logic hit(input modem_ctl_pkg::bus_req_t r,
			input logic [`ADDR_W-1:0] off);
		hit = r.addr == off;
	endfunction

	// Bus request, qualified by chip select
	always_comb begin
		req.rd    = selected(chip_select_a_in, chip_select_b_in,
			chip_select_c_low_n_in) &
			(~read_strobe_low_active_n_in |
			read_strobe_high_active_in);          // [R04]
		req.wr    = selected(chip_select_a_in, chip_select_b_in,
			chip_select_c_low_n_in) & write_strobe_in;
		req.addr  = addr_in;
		req.wdata = wdata_in;
	end

	assign ri_rise   = q.ri_s2 & ~q.ri_prev;        // [R07]
	assign rclk_rise = q.rclk_s2 & ~q.rclk_prev;    // [R03]
	assign mstat_rd  = req.rd & hit(req, `OFF_MSTAT);

	always_comb begin
		logic rts_on;
		logic drop;
		rts_on = 1'b0;
		drop   = 1'b0;
		d = q;

		// Pin synchronisers
		d.ri_s1     = ring_indicator_n_in;
		d.ri_s2     = q.ri_s1;
		d.ri_prev   = q.ri_s2;
		d.rclk_s1   = rx_clock_in;
		d.rclk_s2   = q.rclk_s1;
		d.rclk_prev = q.rclk_s2;

		// Receiver 16x sample enable and bit enable
		d.rx_tick     = rclk_rise;                   // [R03]
		d.rx_bit_tick = rclk_rise && q.sub == `SUB_LAST;
		if (rclk_rise) begin
			d.sub   = q.sub + 4'h1;
			d.ticks = q.ticks + 8'h01;
		end

		// Register writes
		if (req.wr) begin
			case (req.addr)
				`OFF_MCTRL: begin
					d.mctrl = req.wdata;
				end
				`OFF_IRQ_EN: begin
					d.irq_en = req.wdata[`EV_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// Trailing edge flag: a new edge wins over the read clear
		d.ring_trailing_edge_flag = ri_rise |
			(q.ring_trailing_edge_flag & ~mstat_rd);  // [R07] [R12]

		// Request-to-send with automatic threshold drop
		drop   = d.mctrl[`MC_AUTO_RTS] & rx_threshold_in; // [R10]
		rts_on = d.mctrl[`MC_RTS] & ~d.mctrl[`MC_LOOP];
		d.rts_drop = drop & rts_on;
		d.rts_n    = ~(rts_on & ~drop);               // [R09]

		// User outputs, inactive high in loop mode
		d.out_a_n = ~(d.mctrl[`MC_OUT_A] & ~d.mctrl[`MC_LOOP]); // [R01] [R02]
		d.out_b_n = ~(d.mctrl[`MC_OUT_B] & ~d.mctrl[`MC_LOOP]); // [R01] [R02]

		// Sticky events: set wins over clear
		d.irq_stat = q.irq_stat;
		if (req.wr && hit(req, `OFF_IRQ_CLR)) begin
			d.irq_stat = q.irq_stat & ~req.wdata[`EV_W-1:0];
		end
		d.irq_stat[`EV_RING]     = d.irq_stat[`EV_RING] | ri_rise;
		d.irq_stat[`EV_RTS_DROP] = d.irq_stat[`EV_RTS_DROP] |
			(d.rts_drop & ~q.rts_drop);
		d.irq = |(d.irq_stat & d.irq_en);             // [R08]

		// Read data, valid in the cycle after the strobe only
		d.rdata = `RDATA_IDLE;
		if (req.rd) begin
			case (req.addr)
				`OFF_TICKS: begin
					d.rdata = q.ticks;
				end
				`OFF_IRQ_EN: begin
					d.rdata[`EV_W-1:0] = q.irq_en;
				end
				`OFF_IRQ_STAT: begin
					d.rdata[`EV_W-1:0] = q.irq_stat;
				end
				`OFF_MCTRL: begin
					d.rdata = q.mctrl;
				end
				`OFF_MSTAT: begin
					d.rdata[`MS_RING] = ~q.ri_s2;      // [R06]
					d.rdata[`MS_RING_EDGE] =
						q.ring_trailing_edge_flag;      // [R07]
				end
				default: begin
					d.rdata = `RDATA_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			q           <= '0;
			q.mctrl     <= `MCTRL_RST;
			q.irq_en    <= `IRQ_EN_RST;
			q.ri_s1     <= `PIN_IDLE;
			q.ri_s2     <= `PIN_IDLE;
			q.ri_prev   <= `PIN_IDLE;
			q.rts_n     <= `PIN_IDLE;                // [R09]
			q.out_a_n   <= `PIN_IDLE;                // [R02]
			q.out_b_n   <= `PIN_IDLE;                // [R02]
		end else begin
			q <= d;
		end
	end

	assign rdata_out           = q.rdata;
	assign rts_n_out           = q.rts_n;
	assign user_output_a_n_out = q.out_a_n;
	assign user_output_b_n_out = q.out_b_n;
	assign rx_sample_tick_out  = q.rx_tick;
	assign rx_bit_tick_out     = q.rx_bit_tick;
	assign irq_out             = q.irq;

	// Checks
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rstn_in);

	a_out_a_set: assert property ( // [R01]
		req.wr && hit(req, `OFF_MCTRL) && req.wdata[`MC_OUT_A] &&
		!req.wdata[`MC_LOOP] |=> !user_output_a_n_out)
		else $error("user output a not driven low");

	a_out_b_idle: assert property ( // [R02]
		req.wr && hit(req, `OFF_MCTRL) &&
		(!req.wdata[`MC_OUT_B] || req.wdata[`MC_LOOP])
		|=> user_output_b_n_out ##1
		(user_output_b_n_out || $past(req.wr)))
		else $error("user output b not inactive");

	a_rx_sample: assert property ( // [R03]
		rclk_rise |=> rx_sample_tick_out ##1 !rx_sample_tick_out)
		else $error("receiver sample tick wrong");

	a_bit_tick_in: assert property ( // [R03]
		rx_bit_tick_out |-> rx_sample_tick_out && q.sub == 4'h0)
		else $error("bit tick not on sixteenth sample");

	a_read_once: assert property ( // [R04]
		!req.rd |=> rdata_out == `RDATA_IDLE)
		else $error("read data present without read");

	a_ring_level: assert property ( // [R06]
		mstat_rd |=> rdata_out[`MS_RING] == !$past(q.ri_s2))
		else $error("ring status bit wrong");

	a_ring_flag_set: assert property ( // [R07]
		ri_rise |=> q.ring_trailing_edge_flag ##1
		(q.ring_trailing_edge_flag || $past(mstat_rd)))
		else $error("trailing edge flag not set");

	a_ring_flag_clear: assert property ( // [R12]
		mstat_rd && !ri_rise |=> !q.ring_trailing_edge_flag)
		else $error("trailing edge flag not cleared");

	a_ring_irq: assert property ( // [R08]
		ri_rise && q.irq_en[`EV_RING] && !req.wr |=> irq_out)
		else $error("ring interrupt missing");

	a_rts_mctrl: assert property ( // [R09]
		req.wr && hit(req, `OFF_MCTRL) && !req.wdata[`MC_RTS]
		|=> rts_n_out)
		else $error("request-to-send not inactive");

	a_rts_auto: assert property ( // [R10]
		q.mctrl[`MC_AUTO_RTS] && rx_threshold_in && !req.wr
		|=> rts_n_out)
		else $error("auto request-to-send drop missing");

	a_out_a_idle: assert property ( // [R02]
		req.wr && hit(req, `OFF_MCTRL) &&
		(!req.wdata[`MC_OUT_A] || req.wdata[`MC_LOOP])
		|=> user_output_a_n_out)
		else $error("user output a not inactive");

	a_out_b_set: assert property ( // [R01]
		req.wr && hit(req, `OFF_MCTRL) && req.wdata[`MC_OUT_B] &&
		!req.wdata[`MC_LOOP] |=> !user_output_b_n_out)
		else $error("user output b not driven low");

	a_pins_reset: assert property ( // [R02] [R09]
		@(posedge mclk_in) disable iff (1'b0)
		!rstn_in |=> rts_n_out && user_output_a_n_out &&
		user_output_b_n_out)
		else $error("pins not inactive after reset");

	a_loop_idle: assert property ( // [R02] [R09]
		q.mctrl[`MC_LOOP] && !req.wr |=> rts_n_out &&
		user_output_a_n_out && user_output_b_n_out)
		else $error("pins not inactive in loop mode");

	a_rts_set: assert property ( // [R09]
		req.wr && hit(req, `OFF_MCTRL) && req.wdata[`MC_RTS] &&
		!req.wdata[`MC_LOOP] &&
		!(req.wdata[`MC_AUTO_RTS] && rx_threshold_in) |=> !rts_n_out)
		else $error("request-to-send not active");

	a_rts_no_auto: assert property ( // [R10]
		q.mctrl[`MC_RTS] && !q.mctrl[`MC_LOOP] &&
		!q.mctrl[`MC_AUTO_RTS] && !req.wr |=> !rts_n_out)
		else $error("request-to-send dropped without auto mode");

	a_ticks_count: assert property ( // [R03]
		rclk_rise |=> q.ticks == $past(q.ticks) + 8'h01)
		else $error("receiver clock edge not counted");

	a_no_tick: assert property ( // [R03]
		!rclk_rise |=> !rx_sample_tick_out)
		else $error("sample tick without clock edge");

	a_mctrl_read: assert property ( // [R04]
		req.rd && hit(req, `OFF_MCTRL) |=> rdata_out == $past(q.mctrl))
		else $error("modem control read back wrong");

	a_irq_en_read: assert property ( // [R04]
		req.rd && hit(req, `OFF_IRQ_EN)
		|=> rdata_out == `DATA_W'($past(q.irq_en)))
		else $error("interrupt enable read back wrong");

	a_ring_sticky: assert property ( // [R08]
		q.irq_stat[`EV_RING] && !(req.wr && hit(req, `OFF_IRQ_CLR))
		|=> q.irq_stat[`EV_RING])
		else $error("ring status bit lost");

	a_irq_clear: assert property ( // [R08]
		req.wr && hit(req, `OFF_IRQ_CLR) && req.wdata[`EV_RING] &&
		!ri_rise |=> !q.irq_stat[`EV_RING])
		else $error("ring status bit not cleared");

	a_ring_flag_hold: assert property ( // [R07]
		q.ring_trailing_edge_flag && !mstat_rd
		|=> q.ring_trailing_edge_flag)
		else $error("trailing edge flag lost");

endmodule // modem_ctl

`default_nettype wire

/* File: hw/modem_ctl_params.svh */
// Purpose: Constants for the modem control and status pin block
// Assumes: 8-bit register data, 3-bit register address
// Notes:   Register offsets, field positions and reset values
// Operation
// R01: User output pins low while bit set
// R02: User pins high on reset, loop, clear
// R03: Receiver samples on its own 16x clock
// R04: Read when selected and either strobe active
// R05: Host uses one read strobe, ties other
// R06: Status bit 6 shows ring input level
// R07: Ring low-to-high sets trailing edge flag
// R08: Ring trailing edge interrupts when enabled
// R09: Request-to-send follows bit 1, inactive high
// R10: Auto mode lets threshold drop request-to-send
// R11: Host selects with a, b high, c low
// R12: Status read clears trailing edge flag
`ifndef MODEM_CTL_PARAMS_SVH
`define MODEM_CTL_PARAMS_SVH

`define ADDR_W        3
`define DATA_W        8
`define EV_W          2
`define OFF_TICKS     3'h0
`define OFF_IRQ_EN    3'h1
`define OFF_IRQ_STAT  3'h2
`define OFF_IRQ_CLR   3'h3
`define OFF_MCTRL     3'h4
`define OFF_MSTAT     3'h6
`define MC_RTS        1
`define MC_OUT_A      2
`define MC_OUT_B      3
`define MC_LOOP       4
`define MC_AUTO_RTS   5
`define MS_RING_EDGE  2
`define MS_RING       6
`define EV_RING       0
`define EV_RTS_DROP   1
`define MCTRL_RST     8'h00
`define IRQ_EN_RST    2'h0
`define SUB_LAST      4'hF
`define RDATA_IDLE    8'h00
`define PIN_IDLE      1'b1

`endif

/* File: hw/modem_ctl_pkg.sv */
// Purpose: Types for the modem control and status pin block
// Assumes: Constants come from modem_ctl_params.svh
// Notes:   Whole module state is one packed struct
`include "modem_ctl_params.svh"
`default_nettype none

package modem_ctl_pkg;

	typedef struct packed {
		logic               rd;
		logic               wr;
		logic [`ADDR_W-1:0] addr;
		logic [`DATA_W-1:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic [`DATA_W-1:0] mctrl;
		logic [`EV_W-1:0]   irq_en;
		logic [`EV_W-1:0]   irq_stat;
		logic               ring_trailing_edge_flag;
		logic               ri_s1;
		logic               ri_s2;
		logic               ri_prev;
		logic               rclk_s1;
		logic               rclk_s2;
		logic               rclk_prev;
		logic [`DATA_W-1:0] ticks;
		logic [3:0]         sub;
		logic               rts_drop;
		logic [`DATA_W-1:0] rdata;
		logic               rx_tick;
		logic               rx_bit_tick;
		logic               rts_n;
		logic               out_a_n;
		logic               out_b_n;
		logic               irq;
	} state_t;

endpackage

`default_nettype wire
